/* File: src/bsc_map.svh */
// Constants for the branch speculation control block.
// Included by the package and the top module; definitions only.
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH

`define BSC_ADDR_W      32
`define BSC_TAG_W       30
`define BSC_BTC_ENTRIES 64
`define BSC_BTC_IDX_W   6
`define BSC_GRP_BYTES   32'h0000_0010
`define BSC_WB_PORTS    2
`define BSC_MAX_BR      4
`define BSC_MAX_Q_BR    4
`define BSC_MAX_SPEC    2
`define BSC_CNT_W       3
`define BSC_DISP_DELAY  1
`define BSC_EXEC_DELAY  2
`define BSC_RESET_PC    32'h0000_0100
`define BSC_REG_RST     32'h0000_0000

`endif

/* File: src/bsc_pkg.sv */
// Types shared by the branch speculation control block.
// Assumes bsc_map.svh is on the include path.
`include "bsc_map.svh"

package bsc_pkg;

    // Stage that raised a target correction
    typedef enum logic [1:0] {
        BSC_FIX_DECODE   = 2'b00,
        BSC_FIX_DISPATCH = 2'b01,
        BSC_FIX_EXECUTE  = 2'b10,
        BSC_FIX_NONE     = 2'b11
    } bsc_fix_stage_t;

    // Correction request from a pipeline stage
    typedef struct packed {
        logic                   valid;
        bsc_fix_stage_t         stage;
        logic [`BSC_ADDR_W-1:0] target;
    } bsc_fix_t;

    // Branch dispatch event with its new count and link values
    typedef struct packed {
        logic                   valid;
        logic                   predicted;
        logic                   writesCount;
        logic                   writesLink;
        logic [`BSC_ADDR_W-1:0] countVal;
        logic [`BSC_ADDR_W-1:0] linkVal;
    } bsc_brdisp_t;

    // Completion slot presented by the completion buffer, oldest first
    typedef struct packed {
        logic valid;
        logic done;
        logic writesGpr;
        logic finalMulCycle;
        logic isTakenBranch;
    } bsc_slot_t;

    // Saved shadow pair for one unresolved branch
    typedef struct packed {
        logic [`BSC_ADDR_W-1:0] count;
        logic [`BSC_ADDR_W-1:0] link;
    } bsc_shadow_t;

    // Module state apart from the target cache
    typedef struct packed {
        logic [`BSC_ADDR_W-1:0]  fetchPc;
        logic                    fetchValid;
        logic [1:0]              fixWait;
        logic [`BSC_ADDR_W-1:0]  fixTarget;
        logic [`BSC_CNT_W-1:0]   brCount;
        logic [`BSC_CNT_W-1:0]   specCount;
        bsc_shadow_t             shadow;
        bsc_shadow_t [3:0]       saved;
        logic [`BSC_ADDR_W-1:0]  archCount;
        logic [`BSC_ADDR_W-1:0]  archLink;
        logic [1:0]              retire;
        logic [1:0]              wbUsed;
        logic                    flush;
    } bsc_state_t;

endpackage : bsc_pkg

/* File: src/bsc_branch_spec_ctrl.sv */
// Branch timing and speculation control: target cache, correction
// redirect, in-order completion, branch tracking and shadow registers.
// Assumes every pipeline stage runs on clk_sys and obeys its stall outputs.
//
// How it works
// - A target cache hit fetches the predicted group the next cycle.
// - A decode correction fetches the predicted group one cycle after a hit.
// - A dispatch correction runs one cycle later than a decode correction.
// - An execute correction runs two cycles later than a decode correction.
// - Completion is in program order; younger done entries wait.
// - At most two general register write-backs each cycle.
// - A final multiply cycle may write back when a port is free.
// - The slot after a completing taken branch waits one cycle.
// - Track four dispatched branches plus four held in the queue.
// - Speculate past at most two unresolved branches.
// - Architected state changes only after the branch resolves.
// - Record predicted state per branch; flush only the wrong path.
// - Every branch dispatch saves old values and updates the shadows it writes.
// - Correct predictions cost no cycles for shadow handling.
// - A misprediction restores the shadows from the saved values.
// - Architected count and link change only at branch completion.
// - The target cache is 64 entries, fully associative, by fetch address.
`timescale 1ns/1ps
`include "bsc_map.svh"

module bsc_branch_spec_ctrl
    import bsc_pkg::*;
(
    input  wire logic                   clk_sys,        // Core clock
    input  wire logic                   sys_rst,        // Sync reset, high
    input  wire logic                   fetchStall,     // Fetch queue full
    output logic [`BSC_ADDR_W-1:0]      fetchAddr,      // Fetch address
    output logic                        fetchReq,       // Fetch request
    output logic                        fetchPredHit,   // Group from cache
    input  wire logic                   btcWrite,       // Install entry
    input  wire logic [`BSC_ADDR_W-1:0] btcWrAddr,      // Fetch address key
    input  wire logic [`BSC_ADDR_W-1:0] btcWrTarget,    // Taken target
    input  wire bsc_pkg::bsc_fix_t      fix,            // Stage correction
    input  wire bsc_pkg::bsc_brdisp_t   brDisp,         // Branch dispatch
    input  wire logic [`BSC_CNT_W-1:0]  queueBranches,  // Branches queued
    output logic                        brDispStall,    // Hold branches
    output logic                        specStall,      // Hold spec path
    input  wire logic                   brResolve,      // Oldest resolved
    input  wire logic                   brMispredict,   // Resolve was wrong
    input  wire logic                   brComplete,     // Branch completes
    input  wire bsc_pkg::bsc_slot_t [3:0] slots,        // Completion slots
    output logic [1:0]                  retireCount,    // Slots retiring
    output logic [1:0]                  gprWbUsed,      // Ports used
    output logic                        flushYoung,     // Drop wrong path
    output bsc_pkg::bsc_shadow_t        shadowOut,      // Shadow pair
    output logic [`BSC_ADDR_W-1:0]      loopCountReg,   // Architected count
    output logic [`BSC_ADDR_W-1:0]      returnLinkReg   // Architected link
);
    import bsc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Target cache storage

    logic [`BSC_TAG_W-1:0]  btcTag    [`BSC_BTC_ENTRIES];
    logic [`BSC_ADDR_W-1:0] btcTarget [`BSC_BTC_ENTRIES];
    logic [`BSC_BTC_ENTRIES-1:0] btcValid;
    logic [`BSC_BTC_IDX_W-1:0]   btcVictim;

    bsc_state_t st_q;
    bsc_state_t st_d;

    // Fetch address tag, word aligned
    function automatic logic [`BSC_TAG_W-1:0] tagOf(
        input logic [`BSC_ADDR_W-1:0] a
    );
        tagOf = a[`BSC_ADDR_W-1:2];
    endfunction : tagOf

    // Small count step; counts up with wrap, down stops at zero
    function automatic logic [`BSC_CNT_W-1:0] step(
        input logic [`BSC_CNT_W-1:0] v,
        input logic                  up,
        input logic                  dn
    );
        step = v;
        if (up && !dn)
            step = v + `BSC_CNT_W'(1);
        else if (dn && !up && v != '0)
            step = v - `BSC_CNT_W'(1);
    endfunction : step

    ////////////////////////////////////////////////////////////////////
    // Fully associative lookup with the current fetch address

    logic                   btcHit;
    logic [`BSC_ADDR_W-1:0] btcHitTarget;
    logic                   wrMatch;
    logic [`BSC_BTC_IDX_W-1:0] wrIdx;

    always_comb
    begin
        btcHit       = 1'b0;
        btcHitTarget = '0;
        wrMatch      = 1'b0;
        wrIdx        = btcVictim;
        for (int i = 0; i < `BSC_BTC_ENTRIES; i++)
        begin
            if (btcValid[i] && btcTag[i] == tagOf(st_q.fetchPc))
            begin
                btcHit       = 1'b1;
                btcHitTarget = btcTarget[i];
            end
            if (btcValid[i] && btcTag[i] == tagOf(btcWrAddr))
            begin
                wrMatch = 1'b1;
                wrIdx   = `BSC_BTC_IDX_W'(i);
            end
        end
    end

    // Entries are refreshed in place or replaced round-robin; data needs
    // no reset because the valid bits guard it
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            btcValid  <= '0;
            btcVictim <= '0;
        end
        else if (btcWrite)
        begin
            btcTag[wrIdx]    <= tagOf(btcWrAddr);
            btcTarget[wrIdx] <= btcWrTarget;
            btcValid[wrIdx]  <= 1'b1;
            if (!wrMatch)
                btcVictim <= btcVictim + `BSC_BTC_IDX_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    logic [2:0] ready;
    logic       stop;
    logic       mispred;

    always_comb
    begin
        st_d  = st_q;
        ready = '0;
        stop  = 1'b0;
        mispred = brResolve && brMispredict;
        st_d.flush = 1'b0;

        // Fetch sequencing; a pending correction beats the cache
        st_d.fetchValid = 1'b1;
        if (st_q.fixWait != 2'b00)
        begin
            st_d.fixWait = st_q.fixWait - 2'b01;
            if (st_q.fixWait == 2'b01)
                st_d.fetchPc = st_q.fixTarget;
        end
        else if (!fetchStall)
        begin
            if (btcHit)
                st_d.fetchPc = btcHitTarget;
            else
                st_d.fetchPc = st_q.fetchPc + `BSC_GRP_BYTES;
        end

        if (fix.valid && fix.stage != BSC_FIX_NONE)
        begin
            st_d.flush = 1'b1;
            case (fix.stage)
                BSC_FIX_DECODE:
                begin
                    st_d.fetchPc = fix.target;
                    st_d.fixWait = 2'b00;
                end
                BSC_FIX_DISPATCH:
                begin
                    st_d.fixWait   = 2'(`BSC_DISP_DELAY);
                    st_d.fixTarget = fix.target;
                end
                BSC_FIX_EXECUTE:
                begin
                    st_d.fixWait   = 2'(`BSC_EXEC_DELAY);
                    st_d.fixTarget = fix.target;
                end
                default:
                begin
                    st_d.fixWait = 2'b00;
                end
            endcase
        end

        st_d.brCount = step(st_q.brCount, brDisp.valid, brComplete);
        st_d.specCount = step(st_q.specCount,
                              brDisp.valid && brDisp.predicted, brResolve);

        if (brDisp.valid)
        begin
            st_d.saved = {st_q.saved[2:0], st_q.shadow};
            if (brDisp.writesCount)
                st_d.shadow.count = brDisp.countVal;
            if (brDisp.writesLink)
                st_d.shadow.link = brDisp.linkVal;
        end

        if (mispred)
        begin
            st_d.flush = 1'b1;
            st_d.shadow    = st_q.saved[st_q.specCount == '0 ? 0 :
                                        st_q.specCount - `BSC_CNT_W'(1)];
            st_d.specCount = '0;
        end

        if (brComplete)
        begin
            st_d.archCount = st_q.shadow.count;
            st_d.archLink  = st_q.shadow.link;
        end

        st_d.retire = '0;
        st_d.wbUsed = '0;
        for (int i = 0; i < 3; i++)
        begin
            ready[i] = slots[i].valid &&
                       (slots[i].done || slots[i].finalMulCycle);
            if (!stop && ready[i])
            begin
                if (slots[i].writesGpr && st_d.wbUsed == 2'(`BSC_WB_PORTS))
                    stop = 1'b1;
                else
                begin
                    st_d.retire = st_d.retire + 2'b01;
                    if (slots[i].writesGpr)
                        st_d.wbUsed = st_d.wbUsed + 2'b01;
                    if (slots[i].isTakenBranch)
                        stop = 1'b1;
                end
            end
            else
                stop = 1'b1;
        end

        if (sys_rst)
        begin
            st_d           = '0;
            st_d.fetchPc   = `BSC_RESET_PC;
            st_d.archCount = `BSC_REG_RST;
            st_d.archLink  = `BSC_REG_RST;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    // Prediction flag follows the cache at the registered address
    assign fetchAddr     = st_q.fetchPc;
    assign fetchReq      = st_q.fetchValid && st_q.fixWait == 2'b00;
    assign fetchPredHit  = btcHit;
    // stall at four in flight or more than four queued
    assign brDispStall   = st_q.brCount >= `BSC_CNT_W'(`BSC_MAX_BR) ||
                           queueBranches > `BSC_CNT_W'(`BSC_MAX_Q_BR);
    assign specStall     = st_q.specCount >= `BSC_CNT_W'(`BSC_MAX_SPEC);
    assign retireCount   = st_q.retire;
    assign gprWbUsed     = st_q.wbUsed;
    assign flushYoung    = st_q.flush;
    assign shadowOut     = st_q.shadow;
    assign loopCountReg  = st_q.archCount;
    assign returnLinkReg = st_q.archLink;

endmodule : bsc_branch_spec_ctrl

/* File: bench/bsc_spec_chk_assertions.sv */
// Checker for the branch speculation control block.
// Assumes it is bound to bsc_branch_spec_ctrl and sees only its ports.
`timescale 1ns/1ps
`include "bsc_map.svh"
module bsc_spec_chk
    import bsc_pkg::*;
(
    input wire logic                    clk_sys,       // Core clock
    input wire logic                    sys_rst,       // Sync reset
    input wire logic [`BSC_ADDR_W-1:0]  fetchAddr,     // Fetch address
    input wire logic                    fetchReq,      // Fetch request
    input wire bsc_pkg::bsc_fix_t       fix,           // Correction
    input wire bsc_pkg::bsc_brdisp_t    brDisp,        // Dispatch
    input wire logic                    brResolve,     // Resolved
    input wire logic                    brMispredict,  // Wrong guess
    input wire logic                    brComplete,    // Completes
    input wire bsc_pkg::bsc_slot_t [3:0] slots,        // Slots
    input wire logic [1:0]              retireCount,   // Retiring
    input wire logic [1:0]              gprWbUsed,     // Ports used
    input wire logic                    flushYoung,    // Flush
    input wire bsc_pkg::bsc_shadow_t    shadowOut,     // Shadows
    input wire logic [`BSC_ADDR_W-1:0]  loopCountReg,  // Count
    input wire logic [`BSC_ADDR_W-1:0]  returnLinkReg  // Link
);
    ////////////////////////////////
    // One clock domain, so clocking and reset are given once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // Redirect and flush timing
    a_fix_flush: assert property (
        fix.valid && fix.stage != BSC_FIX_NONE |=> flushYoung)
        else $error("no flush after correction");
    a_mis_flush: assert property (
        brResolve && brMispredict |=> flushYoung)
        else $error("no flush after mispredict");
    a_dec_redirect: assert property (
        fix.valid && fix.stage == BSC_FIX_DECODE
        |=> fetchAddr == $past(fix.target)) else $error("decode late");
    a_disp_redirect: assert property (
        fix.valid && fix.stage == BSC_FIX_DISPATCH
        |=> !fetchReq ##1 fetchAddr == $past(fix.target, 2))
        else $error("dispatch redirect off");
    a_exec_redirect: assert property (
        fix.valid && fix.stage == BSC_FIX_EXECUTE
        |=> !fetchReq [*2] ##1 fetchAddr == $past(fix.target, 3))
        else $error("execute redirect off");
    ////////////////////////////////
    // Completion order and write-back ports
    a_wb_limit: assert property (
        gprWbUsed != 2'h3 && gprWbUsed <= retireCount)
        else $error("too many write-backs");
    a_in_order: assert property (
        !(slots[0].valid && (slots[0].done || slots[0].finalMulCycle))
        |=> retireCount == 2'h0) else $error("retired past oldest");
    a_mul_final: assert property (
        slots[0].valid && !slots[0].done && slots[0].finalMulCycle
        |=> retireCount != 2'h0) else $error("final multiply held");
    a_taken_stop: assert property (
        slots[0].valid && slots[0].done && slots[0].isTakenBranch
        |=> retireCount == 2'h1) else $error("retired past taken");
    ////////////////////////////////
    // Shadow and architected registers
    a_shadow_upd: assert property (
        brDisp.valid && brDisp.writesCount && !(brResolve && brMispredict)
        |=> shadowOut.count == $past(brDisp.countVal))
        else $error("shadow count not updated");
    a_arch_hold: assert property (
        !brComplete |=> $stable(loopCountReg) && $stable(returnLinkReg))
        else $error("architected moved early");

    c_taken: cover property (slots[0].valid && slots[0].isTakenBranch);
    c_exec_fix: cover property (fix.valid && fix.stage == BSC_FIX_EXECUTE);
    c_restore: cover property (brResolve && brMispredict);
endmodule : bsc_spec_chk

bind bsc_branch_spec_ctrl bsc_spec_chk bsc_spec_chk_i (
    .clk_sys, .sys_rst, .fetchAddr, .fetchReq, .fix, .brDisp, .brResolve,
    .brMispredict, .brComplete, .slots, .retireCount, .gprWbUsed,
    .flushYoung, .shadowOut, .loopCountReg, .returnLinkReg
);

/* File: bench/bsc_fetch_model.sv */
// Fetch queue model standing behind the block's fetch port.
// Assumes the block's clk_sys and sys_rst.
`timescale 1ns/1ps
module bsc_fetch_model (
    input  wire logic       clk_sys,    // Core clock
    input  wire logic       sys_rst,    // Sync reset, high
    input  wire logic       fetchReq,   // Group requested
    input  wire logic [1:0] mode,       // 0 fast, 1 hold, 2 slow
    output logic            fetchStall  // Queue refuses
);
    logic [2:0] depth_q;
    logic       tick_q;
    // Hold mode or a full four-group queue refuses the next group
    assign fetchStall = (mode == 2'h1) || (depth_q == 3'h4);
    // Slow mode drains every other cycle, so the queue fills and stalls
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            depth_q <= '0;
            tick_q  <= 1'b0;
        end
        else
        begin
            tick_q  <= ~tick_q;
            depth_q <= depth_q + 3'(fetchReq && !fetchStall)
                       - 3'(depth_q != 3'h0 && (mode == 2'h0 || tick_q));
        end
    end
endmodule : bsc_fetch_model

/* File: bench/bsc_branch_spec_ctrl_tb.sv */
// Self-checking bench for the branch speculation control block.
// Assumes bsc_map.svh on the include path and the checker bound.
`timescale 1ns/1ps
`include "bsc_map.svh"
module bsc_branch_spec_ctrl_tb;
    import bsc_pkg::*;
    logic                   clk_sys, sys_rst, fetchStall, fetchReq;
    logic                   fetchPredHit, btcWrite, brDispStall, specStall;
    logic                   brResolve, brMispredict, brComplete, flushYoung;
    logic                   rndOn, pend;
    logic [`BSC_ADDR_W-1:0] fetchAddr, btcWrAddr, btcWrTarget, a, shC, shL;
    logic [`BSC_ADDR_W-1:0] loopCountReg, returnLinkReg;
    logic [`BSC_CNT_W-1:0]  queueBranches;
    logic [1:0]             retireCount, gprWbUsed, mode;
    logic [3:0]             expRet;
    bsc_fix_t               fix;
    bsc_brdisp_t            brDisp;
    bsc_slot_t [3:0]        slots = '0;
    bsc_shadow_t            shadowOut;
    bsc_shadow_t            saved[$];
    int                     num_errors, n_tests, seed, n;

    bsc_branch_spec_ctrl bsc_branch_spec_ctrl_i (.clk_sys, .sys_rst,
        .fetchStall, .fetchAddr, .fetchReq, .fetchPredHit, .btcWrite,
        .btcWrAddr, .btcWrTarget, .fix, .brDisp, .queueBranches,
        .brDispStall, .specStall, .brResolve, .brMispredict, .brComplete,
        .slots, .retireCount, .gprWbUsed, .flushYoung, .shadowOut,
        .loopCountReg, .returnLinkReg);
    bsc_fetch_model bsc_fetch_model_i (.clk_sys, .sys_rst, .fetchReq,
        .mode, .fetchStall);
    ////////////////////////////////
    // 20 MHz core clock
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic compare(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : compare

    task automatic test_done();
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    // Reference retirement: in order, two ports, stop after a taken branch
    function automatic logic [3:0] refRetire(input bsc_slot_t [3:0] s);
        int r;
        int w;
        r = 0;
        w = 0;
        for (int i = 0; i < 3; i++)
        begin
            if (!(s[i].valid && (s[i].done || s[i].finalMulCycle))) break;
            if (s[i].writesGpr && w == 2) break;
            r++;
            w += s[i].writesGpr;
            if (s[i].isTakenBranch) break;
        end
        return {w[1:0], r[1:0]};
    endfunction : refRetire

    // Correction at a stage; counts cycles until fetch lands on the target
    task automatic redirect(input logic [1:0] s, input logic [31:0] t);
        @(posedge clk_sys);
        fix <= '{1'b1, bsc_fix_stage_t'(s), t};
        @(posedge clk_sys);
        fix <= '0;
        n = 0;
        do begin @(negedge clk_sys); n++; end
        while (fetchAddr !== t && n < 8);
        compare(n, s + 1);
    endtask : redirect

    // Branch dispatch; the model saves shadows only for predicted ones
    task automatic disp(input logic p, w, input logic [31:0] v);
        @(posedge clk_sys);
        brDisp <= '{1'b1, p, w, w, v, ~v};
        @(posedge clk_sys);
        brDisp <= '0;
        if (p) saved.push_back('{shC, shL});
        if (w) {shC, shL} = {v, ~v};
    endtask : disp

    // Resolve, mispredict or complete pulse, then let it land
    task automatic step(input logic rs, mp, cp);
        @(posedge clk_sys);
        {brResolve, brMispredict, brComplete} <= {rs, mp, cp};
        @(posedge clk_sys);
        {brResolve, brMispredict, brComplete} <= 3'h0;
        if (rs && mp) {shC, shL} = saved[0];
        if (rs && mp) saved.delete();
        else if (rs) void'(saved.pop_front());
        @(negedge clk_sys);
    endtask : step
    ////////////////////////////////
    // Random completion slots; expectation taken from what the edge saw
    always @(posedge clk_sys)
    begin
        pend = rndOn;
        expRet = refRetire(slots);
        slots <= rndOn ? 20'($random(seed)) : '0;
    end
    always @(negedge clk_sys)
    begin
        if (pend) compare(retireCount, expRet[1:0]);
        if (pend) compare(gprWbUsed, expRet[3:2]);
    end

    // Watchdog, far beyond the roughly 370 cycles the tests take
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        num_errors++;
        test_done();
    end

    // Main sequence
    initial
    begin
        {sys_rst, btcWrite, brResolve, brMispredict, brComplete} = 5'h10;
        {btcWrAddr, btcWrTarget, shC, shL, queueBranches} = '0;
        {fix, brDisp, mode, rndOn, pend, num_errors, n_tests} = '0;
        seed = 31;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        compare(fetchAddr, `BSC_RESET_PC);
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(negedge clk_sys);
        a = fetchAddr;
        @(negedge clk_sys);
        compare(fetchAddr, a + `BSC_GRP_BYTES);
        // Install a cache entry while fetch is held, then release
        @(posedge clk_sys);
        mode <= 2'h1;
        @(negedge clk_sys);
        a = fetchAddr;
        @(posedge clk_sys);
        {btcWrite, btcWrAddr, btcWrTarget} <= {1'b1, a, 32'h0000_2000};
        @(posedge clk_sys);
        btcWrite <= 1'b0;
        @(negedge clk_sys);
        compare(fetchPredHit, 1'b1);
        @(posedge clk_sys);
        mode <= 2'h0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        compare(fetchAddr, 32'h0000_2000);
        for (int s = 0; s < 3; s++) redirect(s[1:0], 32'h3000 + s * 256);
        // Branch tracking limit, by dispatch count and by queue count
        repeat (4) disp(1'b0, 1'b0, 32'h0);
        @(negedge clk_sys);
        compare(brDispStall, 1'b1);
        repeat (4) step(1'b0, 1'b0, 1'b1);
        compare(brDispStall, 1'b0);
        @(posedge clk_sys);
        queueBranches <= 3'h5;
        repeat (2) @(negedge clk_sys);
        compare(brDispStall, 1'b1);
        @(posedge clk_sys);
        queueBranches <= 3'h0;
        // Two speculative branches, one right guess, one wrong
        disp(1'b1, 1'b1, 32'h11);
        disp(1'b1, 1'b1, 32'h22);
        @(negedge clk_sys);
        compare(shadowOut, {shC, shL});
        compare(specStall, 1'b1);
        compare(loopCountReg, 32'h0);
        step(1'b1, 1'b0, 1'b0);
        compare(shadowOut, {shC, shL});
        compare(specStall, 1'b0);
        step(1'b1, 1'b1, 1'b0);
        compare(shadowOut, {shC, shL});
        step(1'b0, 1'b0, 1'b1);
        compare({loopCountReg, returnLinkReg}, {shC, shL});
        // Random completion traffic with a slow fetch queue
        @(posedge clk_sys);
        {mode, rndOn} <= {2'h2, 1'b1};
        repeat (300) @(posedge clk_sys);
        rndOn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        test_done();
    end
endmodule : bsc_branch_spec_ctrl_tb
